// *** common/dtc_consts.svh ***
// offsets, field positions, reset values and timing counts of the dual timer/counter block
// Operation
// - three 16-bit timers, each also an event counter
// - timer advances once per machine cycle
// - counter samples pin, counts one-to-zero changes
// - gate set: run needs pin high and run
// - function select: 0 timer, 1 counter
// - mode 00 is 13-bit timer/counter
// - mode 01 is full 16-bit timer/counter
// - mode 10 is 8-bit auto-reload
// - first timer mode 11 splits into two bytes
// - second timer mode 11 holds its count
// - overflow flag set by hardware, cleared by ack/write
// - edge flag set on edge, cleared when processed
// - type set: falling edge; clear: low level
// - output enable: third overflow in timer mode toggles port1 bit zero
// - down count enable lets third timer count down
// - cycle option 0 gives 6, 1 gives 12 clocks
// - 13/16-bit modes flag on roll to zero
// - auto-reload: low reloads from high, flag set
// - split high byte uses second run and flag
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_OFF_MODE      12'h000
`define DTC_OFF_CTRL      12'h004
`define DTC_OFF_CNT0      12'h008
`define DTC_OFF_CNT1      12'h00c
`define DTC_OFF_CNT2      12'h010
`define DTC_OFF_RLD2      12'h014
`define DTC_OFF_XMODE     12'h018
`define DTC_OFF_CTRL2     12'h01c
`define DTC_OFF_OPT       12'h020
`define DTC_BIT_TF1       7
`define DTC_BIT_TR1       6
`define DTC_BIT_TF0       5
`define DTC_BIT_TR0       4
`define DTC_BIT_IE1       3
`define DTC_BIT_IT1       2
`define DTC_BIT_IE0       1
`define DTC_BIT_IT0       0
`define DTC_BIT_DOWN_COUNT_ENABLE      0
`define DTC_BIT_OE        1
`define DTC_BIT_TR2       0
`define DTC_BIT_CT2       1
`define DTC_BIT_TF2       2
`define DTC_BIT_CYC       0
`define DTC_RST_MODE      8'h00
`define DTC_RST_CTRL      8'h00
`define DTC_RST_OPT       8'hff
`define DTC_CLK_12T       4'd12
`define DTC_CLK_6T        4'd6
`endif

// *** common/dtc_pkg.sv ***
// types of the dual timer/counter block
package dtc_pkg;
  typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_MSPLIT} dtc_msel_type;
  typedef struct packed {
    logic         gate;
    logic         ct;
    dtc_msel_type msel;
  } dtc_tmode_type;
  typedef struct packed {
    dtc_tmode_type t1;
    dtc_tmode_type t0;
  } dtc_mode_type;
  typedef struct packed {
    logic        ovf;
    logic [15:0] cnt;
  } dtc_step_type;
endpackage

// *** core/dtc_top.sv ***
// dual timer/counter with third up/down timer and axi4-lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_top (
  input  wire logic        aclk,                   // 50 mhz clock
  input  wire logic        aresetn,                // sync reset, active low
  input  wire logic [11:0] s_axi_awaddr,           // write address
  input  wire logic        s_axi_awvalid,          // write address valid
  output logic             s_axi_awready,          // write address ready
  input  wire logic [31:0] s_axi_wdata,            // write data
  input  wire logic [3:0]  s_axi_wstrb,            // byte enables
  input  wire logic        s_axi_wvalid,           // write data valid
  output logic             s_axi_wready,           // write data ready
  output logic [1:0]       s_axi_bresp,            // write response
  output logic             s_axi_bvalid,           // write response valid
  input  wire logic        s_axi_bready,           // write response ready
  input  wire logic [11:0] s_axi_araddr,           // read address
  input  wire logic        s_axi_arvalid,          // read address valid
  output logic             s_axi_arready,          // read address ready
  output logic [31:0]      s_axi_rdata,            // read data
  output logic [1:0]       s_axi_rresp,            // read response
  output logic             s_axi_rvalid,           // read data valid
  input  wire logic        s_axi_rready,           // read data ready
  input  wire logic        first_count_pin,        // timer 0 event input
  input  wire logic        second_count_pin,       // timer 1 event input
  input  wire logic        third_count_pin,        // timer 2 event input
  input  wire logic        third_dir_pin,          // timer 2 direction, 1 up
  input  wire logic [1:0]  gating_interrupt_pin_n, // external interrupts a/b, active low
  input  wire logic [3:0]  irq_vector_ack,         // vectored: {ext b, t1, ext a, t0}
  output logic [4:0]       irq_flags,              // {tf2, ie1, tf1, ie0, tf0}
  output logic             port1_bit_zero          // timer 2 clock out
);
  import dtc_pkg::*;

  dtc_mode_type mode_q;
  logic [7:0]   ctrl_q, opt_q, xmode_q, ctrl2_q;
  logic [15:0]  cnt0_q, cnt1_q, cnt2_q, rld2_q;
  logic [3:0]   div_q;
  logic         tick_q, p1_q;
  logic [2:0]   samp_q;
  logic [1:0]   irq_prev_q;
  logic         aw_rdy_q, w_rdy_q, ar_rdy_q;
  logic [11:0]  awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         do_wr;
  logic [31:0]  rd_mux;
  logic         rd_hit, wr_hit;
  logic [1:0]   run, ev, ct_bit, gate_bit, tr_bit;
  logic [2:0]   edge_ev;
  logic         ev_hi, ev2;
  dtc_step_type step0, step1;
  logic         ovf0, ovf1, ovf0h, ovf2;
  logic [3:0]   cyc_len;

  // step one timer by one event in the 13, 16 and 8-bit reload modes, and the low byte in split mode
  function automatic dtc_step_type tstep(input logic [15:0] c, input dtc_msel_type m);
    dtc_step_type r;
    r.ovf = 1'b0;
    r.cnt = c;
    unique case (m)
      DTC_M13: begin
        r.cnt[4:0] = c[4:0] + 5'h01;
        if (c[4:0] == 5'h1f) begin
          r.cnt[15:8] = c[15:8] + 8'h01;
        end
        r.ovf = (c[15:8] == 8'hff) && (c[4:0] == 5'h1f);
      end
      DTC_M16: begin
        r.cnt = c + 16'h0001;
        r.ovf = (c == 16'hffff);
      end
      DTC_M8R: begin
        r.ovf = (c[7:0] == 8'hff);
        r.cnt[7:0] = r.ovf ? c[15:8] : c[7:0] + 8'h01;
      end
      DTC_MSPLIT: begin
        r.ovf = (c[7:0] == 8'hff);
        r.cnt[7:0] = c[7:0] + 8'h01;
      end
    endcase
    return r;
  endfunction

  // machine cycle divider; the option bit picks the cycle length
  assign cyc_len = opt_q[`DTC_BIT_CYC] ? `DTC_CLK_12T : `DTC_CLK_6T;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == cyc_len - 4'd1);
      div_q  <= (div_q >= cyc_len - 4'd1) ? 4'h0 : div_q + 4'h1;
    end
  end

  // pin sampling once per machine cycle; fast pulses are missed, by design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_q <= 3'h0;
    end else if (tick_q) begin
      samp_q <= {third_count_pin, second_count_pin, first_count_pin};
    end
  end
  assign edge_ev = {3{tick_q}} & samp_q & ~{third_count_pin, second_count_pin, first_count_pin};

  assign ct_bit   = {mode_q.t1.ct, mode_q.t0.ct};
  assign gate_bit = {mode_q.t1.gate, mode_q.t0.gate};
  assign tr_bit   = {ctrl_q[`DTC_BIT_TR1], ctrl_q[`DTC_BIT_TR0]};

  // per-channel run gating and event selection for the first two timers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      assign run[gi] = tr_bit[gi] & (~gate_bit[gi] | gating_interrupt_pin_n[gi]);
      assign ev[gi]  = run[gi] & (ct_bit[gi] ? edge_ev[gi] : tick_q);
    end
  endgenerate

  // split high byte is a plain timer on the second run bit
  assign ev_hi = ctrl_q[`DTC_BIT_TR1] & tick_q;
  assign step0 = tstep(cnt0_q, mode_q.t0.msel);
  assign step1 = tstep(cnt1_q, mode_q.t1.msel);
  assign ovf0  = ev[0] & step0.ovf;
  assign ovf1  = ev[1] & step1.ovf & (mode_q.t1.msel != DTC_MSPLIT);
  assign ovf0h = (mode_q.t0.msel == DTC_MSPLIT) & ev_hi & (cnt0_q[15:8] == 8'hff);
  assign ev2   = ctrl2_q[`DTC_BIT_TR2] & (ctrl2_q[`DTC_BIT_CT2] ? edge_ev[2] : tick_q);
  assign ovf2  = ev2 & ((xmode_q[`DTC_BIT_DOWN_COUNT_ENABLE] & ~third_dir_pin) ? (cnt2_q == rld2_q) : (cnt2_q == 16'hffff));

  // write strobe once address and data are both held
  assign do_wr  = ~aw_rdy_q & ~w_rdy_q & ~s_axi_bvalid;
  assign wr_hit = awaddr_q[1:0] == 2'b00 && awaddr_q <= `DTC_OFF_OPT;

  // merge byte lanes of a write into an old value
  function automatic logic [15:0] merge16(input logic [15:0] old);
    logic [15:0] r;
    r = old;
    if (wstrb_q[0]) begin
      r[7:0] = wdata_q[7:0];
    end
    if (wstrb_q[1]) begin
      r[15:8] = wdata_q[15:8];
    end
    return r;
  endfunction

  // software-only registers: mode, extra mode, option, reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q  <= `DTC_RST_MODE;
      xmode_q <= 8'h00;
      opt_q   <= `DTC_RST_OPT;
      rld2_q  <= 16'h0000;
    end else if (do_wr && wstrb_q[0]) begin
      if (awaddr_q == `DTC_OFF_MODE) mode_q <= wdata_q[7:0];
      if (awaddr_q == `DTC_OFF_XMODE) xmode_q <= {6'h00, wdata_q[1:0]};
      if (awaddr_q == `DTC_OFF_OPT) opt_q <= wdata_q[7:0];
      if (awaddr_q == `DTC_OFF_RLD2) rld2_q <= merge16(rld2_q);
    end else if (do_wr && awaddr_q == `DTC_OFF_RLD2) begin
      rld2_q <= merge16(rld2_q);
    end
  end

  // first timer count; a software write wins over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt0_q <= 16'h0000;
    end else if (do_wr && awaddr_q == `DTC_OFF_CNT0) begin
      cnt0_q <= merge16(cnt0_q);
    end else begin
      if (ev[0]) begin
        cnt0_q[7:0] <= step0.cnt[7:0];
      end
      if (mode_q.t0.msel == DTC_MSPLIT) begin
        if (ev_hi) cnt0_q[15:8] <= cnt0_q[15:8] + 8'h01;
      end else if (ev[0]) begin
        cnt0_q[15:8] <= step0.cnt[15:8];
      end
    end
  end

  // second timer count; mode 11 freezes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt1_q <= 16'h0000;
    end else if (do_wr && awaddr_q == `DTC_OFF_CNT1) begin
      cnt1_q <= merge16(cnt1_q);
    end else if (ev[1] && mode_q.t1.msel != DTC_MSPLIT) begin
      cnt1_q <= step1.cnt;
    end
  end

  // third timer: up, or down when enabled and the direction pin is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt2_q <= 16'h0000;
    end else if (do_wr && awaddr_q == `DTC_OFF_CNT2) begin
      cnt2_q <= merge16(cnt2_q);
    end else if (ev2) begin
      if (xmode_q[`DTC_BIT_DOWN_COUNT_ENABLE] && !third_dir_pin) begin
        cnt2_q <= ovf2 ? 16'hffff : cnt2_q - 16'h0001;
      end else begin
        cnt2_q <= ovf2 ? rld2_q : cnt2_q + 16'h0001;
      end
    end
  end

  // clock out toggles on each third-timer overflow while output enable is set and the timer is not counting events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_q <= 1'b0;
    end else if (ovf2 && xmode_q[`DTC_BIT_OE] && !ctrl2_q[`DTC_BIT_CT2]) begin
      p1_q <= ~p1_q;
    end
  end

  // third timer control; its flag is not raised in clock-out mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl2_q <= 8'h00;
    end else begin
      if (do_wr && wstrb_q[0] && awaddr_q == `DTC_OFF_CTRL2) begin
        ctrl2_q <= {5'h00, wdata_q[2:0]};
      end
      if (ovf2 && !xmode_q[`DTC_BIT_OE]) begin
        ctrl2_q[`DTC_BIT_TF2] <= 1'b1;                                  // set wins over the write
      end
    end
  end

  // control flags; a hardware set in the same cycle beats any clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= `DTC_RST_CTRL;
      irq_prev_q <= 2'b11;
    end else begin
      irq_prev_q <= gating_interrupt_pin_n;
      if (do_wr && wstrb_q[0] && awaddr_q == `DTC_OFF_CTRL) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (irq_vector_ack[0]) ctrl_q[`DTC_BIT_TF0] <= 1'b0;
      if (irq_vector_ack[2]) ctrl_q[`DTC_BIT_TF1] <= 1'b0;
      if (irq_vector_ack[1]) ctrl_q[`DTC_BIT_IE0] <= 1'b0;
      if (irq_vector_ack[3]) ctrl_q[`DTC_BIT_IE1] <= 1'b0;
      if (ovf0) ctrl_q[`DTC_BIT_TF0] <= 1'b1;
      if (mode_q.t0.msel == DTC_MSPLIT ? ovf0h : ovf1) begin
        ctrl_q[`DTC_BIT_TF1] <= 1'b1;
      end
      if (ctrl_q[`DTC_BIT_IT0] ? (irq_prev_q[0] & ~gating_interrupt_pin_n[0]) : ~gating_interrupt_pin_n[0]) begin
        ctrl_q[`DTC_BIT_IE0] <= 1'b1;
      end
      if (ctrl_q[`DTC_BIT_IT1] ? (irq_prev_q[1] & ~gating_interrupt_pin_n[1]) : ~gating_interrupt_pin_n[1]) begin
        ctrl_q[`DTC_BIT_IE1] <= 1'b1;
      end
    end
  end

  // axi write channels: take address and data in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q     <= 1'b1;
      w_rdy_q      <= 1'b1;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_rdy_q     <= 1'b1;
        w_rdy_q      <= 1'b1;
      end
    end
  end
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;

  // read decode; unmapped words read zero with slverr
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `DTC_OFF_MODE:  rd_mux = {24'h0, mode_q};
      `DTC_OFF_CTRL:  rd_mux = {24'h0, ctrl_q};
      `DTC_OFF_CNT0:  rd_mux = {16'h0, cnt0_q};
      `DTC_OFF_CNT1:  rd_mux = {16'h0, cnt1_q};
      `DTC_OFF_CNT2:  rd_mux = {16'h0, cnt2_q};
      `DTC_OFF_RLD2:  rd_mux = {16'h0, rld2_q};
      `DTC_OFF_XMODE: rd_mux = {24'h0, xmode_q};
      `DTC_OFF_CTRL2: rd_mux = {24'h0, ctrl2_q};
      `DTC_OFF_OPT:   rd_mux = {24'h0, opt_q};
      default:        rd_hit = 1'b0;
    endcase
  end

  // axi read channel: one read at a time, data the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_q     <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && ar_rdy_q) begin
      ar_rdy_q     <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      ar_rdy_q     <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = ar_rdy_q;

  assign irq_flags      = {ctrl2_q[`DTC_BIT_TF2], ctrl_q[`DTC_BIT_IE1], ctrl_q[`DTC_BIT_TF1],
                           ctrl_q[`DTC_BIT_IE0], ctrl_q[`DTC_BIT_TF0]};
  assign port1_bit_zero = p1_q;
endmodule

// *** testbench/dtc_pin_model.sv ***
// far-side model driving event, gate and direction pins
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire logic       aclk,                  // clock
  output logic            first_count_pin,       // event 0
  output logic            second_count_pin,      // event 1
  output logic            third_count_pin,       // event 2
  output logic            third_dir_pin,         // t2 direction
  output logic [1:0]      gating_interrupt_pin_n // gate pins
);
  logic [2:0] ev_q = 3'h7;
  logic [2:0] gd_q = 3'h7;
  // event pins idle high, like a pulled-up line
  assign {third_count_pin, second_count_pin, first_count_pin} = ev_q;
  assign {gating_interrupt_pin_n, third_dir_pin} = gd_q;
  // phases outlast a 12-clock machine cycle so sampling sees each
  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge aclk);
      ev_q[idx] <= ~ev_q[idx];
      repeat (13) @(posedge aclk);
    end
  endtask
  task automatic set(input logic [1:0] g, input logic d);
    @(posedge aclk);
    gd_q <= {g, d};
  endtask
endmodule

// *** testbench/dtc_top_checker.sv ***
// port assertions for the dual timer/counter block
`timescale 1ns/1ps
module dtc_top_checker (
  input wire logic        aclk,                   // clk
  input wire logic        aresetn,                // rst
  input wire logic        s_axi_awvalid,          // aw
  input wire logic        s_axi_awready,          // aw
  input wire logic        s_axi_wvalid,           // w
  input wire logic        s_axi_wready,           // w
  input wire logic        s_axi_bvalid,           // b
  input wire logic        s_axi_bready,           // b
  input wire logic        s_axi_arvalid,          // ar
  input wire logic        s_axi_arready,          // ar
  input wire logic        s_axi_rvalid,           // r
  input wire logic        s_axi_rready,           // r
  input wire logic [1:0]  gating_interrupt_pin_n, // ext pins
  input wire logic [3:0]  irq_vector_ack,         // acks
  input wire logic [4:0]  irq_flags,              // flags
  input wire logic        port1_bit_zero          // clock out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // pin a quiet long enough that no edge or level is pending
  sequence a_quiet;
    gating_interrupt_pin_n[0] [*4];
  endsequence
  chk_reset_clean: assert property ($rose(aresetn) |-> irq_flags == 5'h00 && !s_axi_bvalid && !port1_bit_zero)
    else $error("outputs not clear after reset");
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_write_busy: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while busy");
  chk_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  chk_edge_ack_clr: assert property (a_quiet ##0 irq_vector_ack[1] |=> !irq_flags[1])
    else $error("edge flag kept after ack");
  chk_tick_spacing: assert property ($rose(irq_flags[0]) |=> (!$rose(irq_flags[0])) [*5])
    else $error("overflow faster than a machine cycle");
  chk_clkout_noirq: assert property ($changed(port1_bit_zero) |-> !$rose(irq_flags[4]))
    else $error("clock out rollover raised flag");
endmodule
bind dtc_top dtc_top_checker i_chk (.*);

// *** testbench/tb_top.sv ***
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`include "dtc_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  import dtc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, p;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, rd_v, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, irq_vector_ack = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gating_interrupt_pin_n, resp;
  logic [4:0]  irq_flags;
  logic        first_count_pin, second_count_pin, third_count_pin, third_dir_pin, port1_bit_zero;
  int          err_count = 0, num_checks = 0, cyc = 0;
  dtc_top i_dut (.*);
  dtc_pin_model i_pins (.*);
  always #10 aclk = ~aclk;
  // hang guard, far above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // axi4-lite write: each channel dropped once taken, waits for response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rd_v, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rd_v)
  endtask
  task automatic wait_irq(input int b);
    for (int n = 0; n < 3000 && irq_flags[b] !== 1'b1; n++) @(posedge aclk);
  endtask
  // one-cycle vectored acknowledge
  task automatic ack(input int b);
    @(posedge aclk);
    irq_vector_ack[b] <= 1'b1;
    @(posedge aclk);
    irq_vector_ack[b] <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_reset();
    rchk(`DTC_OFF_MODE, 32'h0, "mode reset");
    rchk(`DTC_OFF_CTRL, 32'h0, "ctrl reset");
    rchk(`DTC_OFF_OPT, 32'hff, "option reset");
    rd(12'h024);
    `CHK("unmapped rresp", 2'b10, resp)
    wr(12'h024, 32'h1);
    `CHK("unmapped bresp", 2'b10, resp)
  endtask
  // run timer 0 for a fixed window; the count tracks clocks per cycle
  task automatic t_rate(input logic [31:0] opt, input int per);
    wr(`DTC_OFF_OPT, opt);
    wr(`DTC_OFF_MODE, 32'h01);
    wr(`DTC_OFF_CNT0, 32'h0);
    wr(`DTC_OFF_CTRL, 32'h10);
    repeat (120) @(posedge aclk);
    wr(`DTC_OFF_CTRL, 32'h00);
    rd(`DTC_OFF_CNT0);
    `CHK("tick rate", 1'b1, rd_v >= 120 / per - 1 && rd_v <= 120 / per + 2)
  endtask
  // preload timer 0, run to overflow, ack, stop and read back; in 6-clock cycles one
  // more machine cycle passes between the overflow and the landing of the stop write
  task automatic t_roll(input logic [31:0] md, c0, run, input int fb, input logic [31:0] ec, input string nm);
    wr(`DTC_OFF_MODE, md);
    wr(`DTC_OFF_CNT0, c0);
    wr(`DTC_OFF_CTRL, run);
    wait_irq(fb);
    `CHK(nm, 1'b1, irq_flags[fb])
    ack(fb);
    `CHK(nm, 1'b0, irq_flags[fb])
    wr(`DTC_OFF_CTRL, 32'h00);
    rchk(`DTC_OFF_CNT0, ec, nm);
  endtask
  task automatic t_count();
    wr(`DTC_OFF_MODE, 32'hd0);
    wr(`DTC_OFF_CNT1, 32'h0);
    wr(`DTC_OFF_CTRL, 32'h40);
    i_pins.set(2'h1, 1'b1);
    i_pins.pulse(1, 2);
    i_pins.set(2'h3, 1'b1);
    i_pins.pulse(1, 3);
    rchk(`DTC_OFF_CNT1, 32'h3, "gated count");
    wr(`DTC_OFF_MODE, 32'h30);
    repeat (40) @(posedge aclk);
    rchk(`DTC_OFF_CNT1, 32'h3, "mode3 hold");
    `CHK("ext b level", 1'b1, irq_flags[3])
    ack(3);
    `CHK("ext b cleared", 1'b0, irq_flags[3])
    wr(`DTC_OFF_CTRL, 32'h00);
  endtask
  // edge type: ack with pin still low stays clear; level type re-sets
  task automatic t_ext();
    wr(`DTC_OFF_CTRL, 32'h01);
    i_pins.set(2'h2, 1'b1);
    repeat (4) @(posedge aclk);
    `CHK("edge set", 1'b1, irq_flags[1])
    ack(1);
    repeat (3) @(posedge aclk);
    `CHK("edge no reset", 1'b0, irq_flags[1])
    wr(`DTC_OFF_CTRL, 32'h00);
    ack(1);
    repeat (3) @(posedge aclk);
    `CHK("level re-set", 1'b1, irq_flags[1])
    i_pins.set(2'h3, 1'b1);
    repeat (6) @(posedge aclk);
    ack(1);
    `CHK("level cleared", 1'b0, irq_flags[1])
  endtask
  task automatic t_t2();
    wr(`DTC_OFF_RLD2, 32'hfff8);
    wr(`DTC_OFF_CNT2, 32'hfff8);
    wr(`DTC_OFF_XMODE, 32'h02);
    p = port1_bit_zero;
    wr(`DTC_OFF_CTRL2, 32'h01);
    for (int n = 0; n < 300 && port1_bit_zero === p; n++) @(posedge aclk);
    `CHK("clock out", ~p, port1_bit_zero)
    `CHK("no t2 flag", 1'b0, irq_flags[4])
    wr(`DTC_OFF_CTRL2, 32'h00);
    wr(`DTC_OFF_XMODE, 32'h01);
    wr(`DTC_OFF_RLD2, 32'h0010);
    wr(`DTC_OFF_CNT2, 32'h0012);
    i_pins.set(2'h3, 1'b0);
    wr(`DTC_OFF_CTRL2, 32'h01);
    wait_irq(4);
    `CHK("down flag", 1'b1, irq_flags[4])
    wr(`DTC_OFF_CTRL2, 32'h00);
    rchk(`DTC_OFF_CNT2, 32'hffff, "down wrap");
    // third timer as an event counter, counting up
    wr(`DTC_OFF_XMODE, 32'h00);
    wr(`DTC_OFF_CNT2, 32'h0);
    wr(`DTC_OFF_CTRL2, 32'h03);
    i_pins.pulse(2, 2);
    rchk(`DTC_OFF_CNT2, 32'h2, "t2 events");
    wr(`DTC_OFF_CTRL2, 32'h00);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rate(32'h1, 12);
    t_rate(32'h0, 6);
    t_roll(32'h01, 32'hffff, 32'h10, 0, 32'h0001, "mode16 roll");
    t_roll(32'h00, 32'hffff, 32'h10, 0, 32'h00e1, "mode13 roll");
    t_roll(32'h02, 32'h80ff, 32'h10, 0, 32'h8081, "reload");
    t_roll(32'h03, 32'hfff0, 32'h40, 2, 32'h01f0, "split high");
    t_count();
    t_ext();
    t_t2();
    final_report();
  end
endmodule
